// File: verilog/eqc_page_regs.vh
// register offsets, field positions and reset values of the equalizer and
// clock-recovery page
// assumes inclusion by the register page module eqc_page only
`ifndef EQC_PAGE_REGS_VH
`define EQC_PAGE_REGS_VH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define EQC_OFS_PAGE_SOFT_RESET 8'h00
`define EQC_OFS_SIGNAL_LOSS 8'h01
`define EQC_OFS_CLOCK_RECOVERY 8'h02
`define EQC_OFS_MANUAL_BOOST 8'h03
`define EQC_OFS_SPARE_04 8'h04
`define EQC_OFS_SPARE_05 8'h05
`define EQC_OFS_SPARE_06 8'h06
`define EQC_OFS_SPARE_07 8'h07
`define EQC_OFS_SPARE_08 8'h08
`define EQC_OFS_OUTPUT_OVERRIDE 8'h09

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define EQC_BIT_PAGE_RESET 2
`define EQC_BIT_SIGNAL_LOST 1
`define EQC_BIT_PER_OUTPUT 5
`define EQC_PAGE_CHOICE_THIS 2'h0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EQC_RST_PAGE_SOFT_RESET 8'h00
`define EQC_RST_SIGNAL_LOSS 8'h03
`define EQC_RST_CLOCK_RECOVERY 8'h41
`define EQC_RST_MANUAL_BOOST 8'h80
`define EQC_RST_SPARE 8'h00
`define EQC_RST_OUTPUT_OVERRIDE 8'h00
// read mask of the signal loss byte: bit 0 is a reserved constant one
`define EQC_LOSS_CONST 8'h01

`endif

// File: verilog/eqc_sync.v
// two-flop synchroniser for a group of status levels
// assumes each bit is a slowly changing level; bits are not coherent
`timescale 1ns/1ps

module eqc_sync #(
    parameter WIDTH = 9,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // levels
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] sync_q;

genvar g;
generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
        always @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                meta_q[g] <= RESET_VALUE[g];
                sync_q[g] <= RESET_VALUE[g];
            end else begin
                meta_q[g] <= async_i[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end
endgenerate

assign sync_o = sync_q;

endmodule

// File: verilog/eqc_out_sel.v
// output source selection for the two outputs
// assumes the selection fields arrive from registers on the same clock
`timescale 1ns/1ps

module eqc_out_sel (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // control
    input wire per_output_select_enable_i,
    input wire [1:0] shared_select_i,
    input wire [2:0] first_output_select_i,
    input wire [2:0] second_output_select_i,
    // selection
    output reg [2:0] first_output_source_o,
    output reg [2:0] second_output_source_o
);

always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        first_output_source_o <= 3'h0;
        second_output_source_o <= 3'h0;
    end else if (per_output_select_enable_i) begin
        // RL9: per output choice
        first_output_source_o <= first_output_select_i;
        second_output_source_o <= second_output_select_i;
    end else begin
        // RL8: one shared choice
        first_output_source_o <= {1'b0, shared_select_i};
        second_output_source_o <= {1'b0, shared_select_i};
    end
end

endmodule

// File: verilog/eqc_page.v
// register page of the equalizer and clock-recovery section
// assumes a management port decoder that presents one-cycle read and write
// strobes with an 8-bit offset, and the shared page-select fields
//
// What this block does
// RL1: writing one to bit 2 of offset 0x00 returns every writable register of the page to its default and the bit reads back zero.
// RL2: after such a page reset the host runs the re-initialization procedure before relying on the section.
// RL3: bit 1 of offset 0x01 is read-only and shows zero for signal present and one for signal lost on the second input.
// RL4: offset 0x02 is a read-only clock-recovery status byte that reads 0x41 by default and follows the synchronised clock_recovery_status_i.
// RL5: the manual boost at offset 0x03 drives the second input equalizer only when the manual enable bit is set, else the adaptive value does.
// RL6: the boost byte holds four 2-bit stage controls, stage 0 in bits 7:6 down to stage 3 in bits 1:0, default 0x80.
// RL7: the boost value in use is offered for readback on the eq_boost_readback_o port; no page offset reads it.
// RL8: with bit 5 of offset 0x09 clear both outputs follow the shared 2-bit select field.
// RL9: with that bit set each output follows its own 3-bit select field.
// RL10: accesses reach the page only while page select is enabled with page choice 00.
// RL11: reserved read-write bits hold what is written, return defaults on any reset and steer nothing.
`timescale 1ns/1ps
`include "eqc_page_regs.vh"

module eqc_page (
    // clock and reset
    input wire clk_sys_i,
    input wire reset_n_i,
    // page selection from the shared registers
    input wire page_select_enable_i,
    input wire [1:0] page_choice_i,
    // register access
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rdata_valid_o,
    // analog status levels
    input wire second_input_signal_lost_i,
    input wire [7:0] clock_recovery_status_i,
    // equalizer control
    input wire manual_boost_enable_i,
    input wire [7:0] adaptive_boost_i,
    output reg [7:0] eq_boost_o,
    output wire [1:0] boost_stage_zero_o,
    output wire [1:0] boost_stage_one_o,
    output wire [1:0] boost_stage_two_o,
    output wire [1:0] boost_stage_three_o,
    output wire [7:0] eq_boost_readback_o,
    // output mux control
    input wire [1:0] shared_select_i,
    input wire [2:0] first_output_select_i,
    input wire [2:0] second_output_select_i,
    output wire [2:0] first_output_source_o,
    output wire [2:0] second_output_source_o,
    output wire per_output_select_enable_o,
    // page reset notice
    output reg page_reset_o
);

// ----------------------------------------------------------------------
// access gating
// ----------------------------------------------------------------------
wire page_hit;
wire wr_hit;
wire rd_hit;

// RL10: page routing
assign page_hit = page_select_enable_i &&
    (page_choice_i == `EQC_PAGE_CHOICE_THIS);
assign wr_hit = reg_wr_i && page_hit;
assign rd_hit = reg_rd_i && page_hit;

// ----------------------------------------------------------------------
// synchronised status
// ----------------------------------------------------------------------
wire [8:0] status_sync;
wire signal_lost_sync;
wire [7:0] recovery_sync;

eqc_sync #(
    .WIDTH(9),
    .RESET_VALUE({1'b1, `EQC_RST_CLOCK_RECOVERY})
) u_status_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i({second_input_signal_lost_i, clock_recovery_status_i}),
    .sync_o(status_sync)
);

assign signal_lost_sync = status_sync[8];
assign recovery_sync = status_sync[7:0];

// ----------------------------------------------------------------------
// writable registers
// ----------------------------------------------------------------------
reg [7:0] soft_reset_q;
reg [7:0] manual_boost_q;
reg [7:0] spare_q [4:8];
reg [7:0] override_q;
wire soft_reset_req;

// RL1: self-clearing page reset request
assign soft_reset_req = wr_hit &&
    (reg_addr_i == `EQC_OFS_PAGE_SOFT_RESET) &&
    reg_wdata_i[`EQC_BIT_PAGE_RESET];

always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        page_reset_o <= 1'b0;
    end else begin
        page_reset_o <= soft_reset_req;
    end
end

always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        soft_reset_q <= `EQC_RST_PAGE_SOFT_RESET;
        manual_boost_q <= `EQC_RST_MANUAL_BOOST;
        override_q <= `EQC_RST_OUTPUT_OVERRIDE;
    end else if (page_reset_o) begin
        // RL1: page registers back to defaults
        soft_reset_q <= `EQC_RST_PAGE_SOFT_RESET;
        manual_boost_q <= `EQC_RST_MANUAL_BOOST;
        override_q <= `EQC_RST_OUTPUT_OVERRIDE;
    end else if (wr_hit) begin
        case (reg_addr_i)
            `EQC_OFS_PAGE_SOFT_RESET: begin
                // RL1: trigger bit never stored
                soft_reset_q <= reg_wdata_i &
                    ~(8'h01 << `EQC_BIT_PAGE_RESET);
            end
            `EQC_OFS_MANUAL_BOOST: begin
                manual_boost_q <= reg_wdata_i;
            end
            `EQC_OFS_OUTPUT_OVERRIDE: begin
                override_q <= reg_wdata_i;
            end
            default: begin
                soft_reset_q <= soft_reset_q;
            end
        endcase
    end
end

// RL11: reserved bytes held, defaulted, unused
genvar s;
generate
    for (s = 4; s <= 8; s = s + 1) begin : g_spare
        always @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                spare_q[s] <= `EQC_RST_SPARE;
            end else if (page_reset_o) begin
                spare_q[s] <= `EQC_RST_SPARE;
            end else if (wr_hit && ({24'h000000, reg_addr_i} == s)) begin
                spare_q[s] <= reg_wdata_i;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------------
// equalizer boost
// ----------------------------------------------------------------------
always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        eq_boost_o <= `EQC_RST_MANUAL_BOOST;
    end else if (manual_boost_enable_i) begin
        // RL5: manual boost governs
        eq_boost_o <= manual_boost_q;
    end else begin
        eq_boost_o <= adaptive_boost_i;
    end
end

// RL6: stage split of the boost in use
assign boost_stage_zero_o = eq_boost_o[7:6];
assign boost_stage_one_o = eq_boost_o[5:4];
assign boost_stage_two_o = eq_boost_o[3:2];
assign boost_stage_three_o = eq_boost_o[1:0];
// RL7: boost in use for readback
assign eq_boost_readback_o = eq_boost_o;

// ----------------------------------------------------------------------
// output source selection
// ----------------------------------------------------------------------
assign per_output_select_enable_o = override_q[`EQC_BIT_PER_OUTPUT];

// RL8: shared or per output select
eqc_out_sel u_out_sel (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .per_output_select_enable_i(per_output_select_enable_o),
    .shared_select_i(shared_select_i),
    .first_output_select_i(first_output_select_i),
    .second_output_select_i(second_output_select_i),
    .first_output_source_o(first_output_source_o),
    .second_output_source_o(second_output_source_o)
);

// ----------------------------------------------------------------------
// read path
// ----------------------------------------------------------------------
reg [7:0] rd_mux;

always @* begin
    rd_mux = 8'h00;
    case (reg_addr_i)
        `EQC_OFS_PAGE_SOFT_RESET: begin
            rd_mux = soft_reset_q;
        end
        `EQC_OFS_SIGNAL_LOSS: begin
            // RL3: loss flag read-only
            rd_mux = `EQC_LOSS_CONST |
                ({7'h00, signal_lost_sync} << `EQC_BIT_SIGNAL_LOST);
        end
        `EQC_OFS_CLOCK_RECOVERY: begin
            // RL4: recovery status read-only
            rd_mux = recovery_sync;
        end
        `EQC_OFS_MANUAL_BOOST: begin
            rd_mux = manual_boost_q;
        end
        `EQC_OFS_SPARE_04: begin
            rd_mux = spare_q[4];
        end
        `EQC_OFS_SPARE_05: begin
            rd_mux = spare_q[5];
        end
        `EQC_OFS_SPARE_06: begin
            rd_mux = spare_q[6];
        end
        `EQC_OFS_SPARE_07: begin
            rd_mux = spare_q[7];
        end
        `EQC_OFS_SPARE_08: begin
            rd_mux = spare_q[8];
        end
        `EQC_OFS_OUTPUT_OVERRIDE: begin
            rd_mux = override_q;
        end
        default: begin
            rd_mux = 8'h00;
        end
    endcase
end

always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        reg_rdata_o <= 8'h00;
        reg_rdata_valid_o <= 1'b0;
    end else begin
        reg_rdata_valid_o <= rd_hit;
        if (rd_hit) begin
            reg_rdata_o <= rd_mux;
        end
    end
end

endmodule

// File: sim/eqc_page_chk_asserts.sv
// port checker of the equalizer and clock-recovery page
// assumes binding onto eqc_page, one clock, async low reset
`timescale 1ns/1ps
module eqc_page_chk (
    // clock, reset, access
    input wire clk_sys_i, reset_n_i, page_select_enable_i,
    input wire [1:0] page_choice_i,
    input wire [7:0] reg_addr_i, reg_wdata_i,
    input wire reg_wr_i, reg_rd_i, reg_rdata_valid_o,
    // equalizer
    input wire manual_boost_enable_i,
    input wire [7:0] adaptive_boost_i, eq_boost_o, eq_boost_readback_o,
    input wire [1:0] boost_stage_zero_o, boost_stage_one_o,
    input wire [1:0] boost_stage_two_o, boost_stage_three_o,
    // output mux and page reset
    input wire [1:0] shared_select_i,
    input wire [2:0] first_output_select_i, second_output_select_i,
    input wire [2:0] first_output_source_o, second_output_source_o,
    input wire per_output_select_enable_o, page_reset_o
);
    wire on_page = page_select_enable_i && page_choice_i == 2'h0;
    wire rd_take = on_page && reg_rd_i;
    wire wr_take = on_page && reg_wr_i && !page_reset_o;
    wire ovr_bit = reg_wdata_i[5];
    logic armed_q;
    // keeps attempts off the edge that releases reset
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i || !armed_q);
    property p_rd_ans; rd_take |=> reg_rdata_valid_o; endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("taken read got no valid");
    property p_rd_off; !rd_take |=> !reg_rdata_valid_o; endproperty
    a_rd_off: assert property (p_rd_off)
        else $error("valid without a taken read");
    property p_adapt;
        !manual_boost_enable_i |=> eq_boost_o == $past(adaptive_boost_i);
    endproperty
    a_adapt: assert property (p_adapt)
        else $error("adaptive boost not in use");
    property p_stage; eq_boost_readback_o == eq_boost_o && {boost_stage_zero_o,
        boost_stage_one_o, boost_stage_two_o,
        boost_stage_three_o} == eq_boost_o;
    endproperty
    a_stage: assert property (p_stage)
        else $error("stage split or readback wrong");
    property p_shared; !per_output_select_enable_o |=>
        first_output_source_o == {1'b0, $past(shared_select_i)} &&
        second_output_source_o == {1'b0, $past(shared_select_i)};
    endproperty
    a_shared: assert property (p_shared)
        else $error("outputs not on shared select");
    property p_indiv; per_output_select_enable_o |=>
        first_output_source_o == $past(first_output_select_i) &&
        second_output_source_o == $past(second_output_select_i);
    endproperty
    a_indiv: assert property (p_indiv)
        else $error("outputs not on own selects");
    property p_ovr;
        wr_take && reg_addr_i == 8'h09 |=>
            per_output_select_enable_o == $past(ovr_bit);
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("override bit not taken");
    property p_soft; wr_take && reg_addr_i == 8'h00 && reg_wdata_i[2] |=>
        page_reset_o ##1 !page_reset_o && !per_output_select_enable_o;
    endproperty
    a_soft: assert property (p_soft)
        else $error("page reset pulse or defaults wrong");
endmodule
bind eqc_page eqc_page_chk chk_i (.*);

// File: sim/eqc_host_model.sv
// host side model driving the page access strobes
// assumes one clock shared with the page
`timescale 1ns/1ps
module eqc_host_model (
    input wire clk_sys_i,
    // page choice
    output reg page_en_o = 1'b0,
    output reg [1:0] page_choice_o = 2'h3,
    // access
    output reg [7:0] addr_o = 8'h00,
    output reg [7:0] wdata_o = 8'h00,
    output reg wr_o = 1'b0,
    output reg rd_o = 1'b0,
    input wire [7:0] rdata_i,
    input wire valid_i
);
    task sel(input en, input [1:0] ch);
        begin
            @(posedge clk_sys_i);
            page_en_o <= en;
            page_choice_o <= ch;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys_i);
            addr_o <= a;
            wdata_o <= d;
            wr_o <= 1'b1;
            @(posedge clk_sys_i);
            wr_o <= 1'b0;
            // released bus shows inverted leftovers
            addr_o <= ~a;
            wdata_o <= ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d, output v);
        begin
            @(posedge clk_sys_i);
            addr_o <= a;
            rd_o <= 1'b1;
            @(posedge clk_sys_i);
            rd_o <= 1'b0;
            addr_o <= ~a;
            @(posedge clk_sys_i);
            d = rdata_i;
            v = valid_i;
        end
    endtask
endmodule

// File: sim/eqc_page_tb.sv
// self-checking bench of the equalizer and clock-recovery page
// assumes eqc_page, its checker and the host model
`timescale 1ns/1ps
module eqc_page_tb;
    reg clk_sys_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg second_input_signal_lost_i = 1'b1;
    reg [7:0] clock_recovery_status_i = 8'h41;
    reg manual_boost_enable_i = 1'b0;
    reg [7:0] adaptive_boost_i = 8'h3C;
    reg [1:0] shared_select_i = 2'h3;
    reg [2:0] first_output_select_i = 3'h5;
    reg [2:0] second_output_select_i = 3'h2;
    wire page_select_enable_i, reg_wr_i, reg_rd_i, reg_rdata_valid_o;
    wire [1:0] page_choice_i, boost_stage_zero_o, boost_stage_one_o;
    wire [1:0] boost_stage_two_o, boost_stage_three_o;
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, eq_boost_o;
    wire [7:0] eq_boost_readback_o;
    wire [2:0] first_output_source_o, second_output_source_o;
    wire per_output_select_enable_o, page_reset_o;
    localparam [79:0] dflt_bytes = 80'h00_03_41_80_00_00_00_00_00_00;
    integer n_mismatch = 0;
    integer samples_checked = 0;
    integer i;
    reg [7:0] d;
    reg v;

    always #2 clk_sys_i = ~clk_sys_i;
    eqc_page dut (.*);
    eqc_host_model host (.clk_sys_i(clk_sys_i),
        .page_en_o(page_select_enable_i), .page_choice_o(page_choice_i),
        .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i),
        .rd_o(reg_rd_i), .rdata_i(reg_rdata_o), .valid_i(reg_rdata_valid_o));

    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        begin
            host.rd(a, d, v);
            chk("read valid", {7'h00, v}, 8'h01);
            chk("read data", d, e);
        end
    endtask
    task waitc(input integer n);
        begin
            repeat (n) @(posedge clk_sys_i);
            #1;
        end
    endtask
    task final_report;
        begin
            $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        host.sel(1'b1, 2'h0);
        for (i = 0; i < 10; i = i + 1)
            rdc(i[7:0], dflt_bytes[79-8*i -: 8]);
        host.wr(8'h00, 8'hFB);
        rdc(8'h00, 8'hFB);
        for (i = 3; i < 10; i = i + 1)
            host.wr(i[7:0], i[7:0] + 8'hA0);
        for (i = 3; i < 10; i = i + 1)
            rdc(i[7:0], i[7:0] + 8'hA0);
        host.wr(8'h01, 8'hFF);
        host.wr(8'h02, 8'h00);
        host.wr(8'h0A, 8'h5A);
        rdc(8'h01, 8'h03);
        rdc(8'h02, 8'h41);
        rdc(8'h0A, 8'h00);
        chk("first source", {5'h00, first_output_source_o}, 8'h05);
        chk("second source", {5'h00, second_output_source_o}, 8'h02);
        host.wr(8'h09, 8'h00);
        waitc(2);
        chk("first shared", {5'h00, first_output_source_o}, 8'h03);
        chk("second shared", {5'h00, second_output_source_o}, 8'h03);
        chk("adaptive boost", eq_boost_o, 8'h3C);
        @(posedge clk_sys_i) manual_boost_enable_i <= 1'b1;
        waitc(2);
        chk("manual boost", eq_boost_o, 8'hA3);
        chk("stages", {boost_stage_zero_o, boost_stage_one_o,
            boost_stage_two_o, boost_stage_three_o}, 8'hA3);
        chk("readback", eq_boost_readback_o, 8'hA3);
        @(posedge clk_sys_i) second_input_signal_lost_i <= 1'b0;
        clock_recovery_status_i <= 8'h5A;
        waitc(3);
        rdc(8'h01, 8'h01);
        rdc(8'h02, 8'h5A);
        host.sel(1'b1, 2'h1);
        host.wr(8'h03, 8'h11);
        host.rd(8'h03, d, v);
        chk("off page valid", {7'h00, v}, 8'h00);
        host.sel(1'b0, 2'h0);
        host.rd(8'h03, d, v);
        chk("paging off valid", {7'h00, v}, 8'h00);
        host.sel(1'b1, 2'h0);
        rdc(8'h03, 8'hA3);
        host.wr(8'h09, 8'h20);
        host.wr(8'h00, 8'h04);
        for (i = 3; i < 10; i = i + 1)
            rdc(i[7:0], dflt_bytes[79-8*i -: 8]);
        rdc(8'h00, 8'h00);
        rdc(8'h02, 8'h5A);
        host.wr(8'h09, 8'h20);
        rdc(8'h09, 8'h20);
        final_report;
    end

    initial begin
        #20000;
        n_mismatch = n_mismatch + 1;
        final_report;
    end
endmodule
